// [design/ncd_core.sv]
// Nibble CPU datapath: fetch, PC, RAM, accumulator and I/O registers
//
// Contract
// - 11-bit PC addresses 2048 program bytes
// - paged ops see 32 pages of 64
// - non-transfer cycles load PC plus one
// - three-level LIFO stack of 11-bit entries
// - RAM holds 8 rows of 16 nibbles
// - pointer: 3-bit row, 4-bit digit
// - RAM nibble moves with A, Q, L
// - direct ops address RAM from operand
// - digit select copied to digit outputs
// - A loads pointer, Q halves, G register
// - 4-bit adder writes A and carry
// - carry drives serial clock or sync gate
// - general register drives readable port pins
// - 8-bit port latch drives pins when enabled
// - byte port pins readable into A, RAM
// - serial register shifts or counts, swaps A
// - 8 shared pins carry address then byte
// - skip shares top address pin; 8, 9
// - instruction cycle is 32 oscillator periods
// - address out while flag high, else input
// - lowest enable bit selects counter mode
`timescale 1ns/1ps
module ncd_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic osc_input,
    input wire logic [7:0] instr_bus_in,
    output logic [7:0] instr_bus_out,
    output logic instr_bus_oe,
    output logic addr_phase,
    output logic addr_bit_eight,
    output logic addr_bit_nine,
    output logic skip_or_top_addr,
    input wire logic skip_flag,
    input wire ncd_pkg::ncd_op_t op_code,
    input wire logic [10:0] op_arg,
    input wire logic op_high_half,
    input wire logic [3:0] enable_bits,
    output logic [3:0] d_out,
    input wire logic [3:0] g_in,
    output logic [3:0] g_out,
    output logic [3:0] g_oe,
    input wire logic [7:0] l_in,
    output logic [7:0] l_out,
    output logic [7:0] l_oe,
    input wire logic [3:0] gp_sense_lines,
    input wire logic serial_in,
    output logic serial_clock_pin,
    output logic serial_out,
    output logic [7:0] instr_byte,
    output logic cycle_pulse,
    output logic [3:0] acc_value,
    output logic carry_value
);
    // Increment across the full 11-bit program space
    function automatic logic [10:0] inc11(input logic [10:0] v);
        inc11 = v + 11'h001;
    endfunction : inc11

    // Nibble add with carry in; bit 4 is carry out
    function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b,
                                       input logic cin);
        add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    endfunction : add4

    // Synchronised pin levels
    logic osc_s; // Oscillator level
    logic ser_s; // Serial input level
    logic [7:0] ibus_s; // Instruction bus
    logic [7:0] l_s; // Byte port pins
    logic [3:0] g_s; // General port pins
    logic [3:0] in_s; // Sense lines

    ncd_sync3 #(.W(1)) u_sync_osc (.clk_sys(clk_sys), .rst_n(rst_n),
        .pin_in(osc_input), .level_out(osc_s));
    ncd_sync3 #(.W(1)) u_sync_ser (.clk_sys(clk_sys), .rst_n(rst_n),
        .pin_in(serial_in), .level_out(ser_s));
    logic [3:0] ser_unused; // Pad lanes, tied low at the input
    ncd_sync3 #(.W(28)) u_sync_bus (.clk_sys(clk_sys), .rst_n(rst_n),
        .pin_in({instr_bus_in, l_in, g_in, gp_sense_lines, 4'h0}),
        .level_out({ibus_s, l_s, g_s, in_s, ser_unused}));

    // Stack link
    ncd_stack_if stk_if ();
    ncd_ret_stack u_stack (.clk_sys(clk_sys), .rst_n(rst_n), .stk(stk_if.store));

    // Architectural registers
    logic [10:0] pc_reg; // Address of the byte being fetched
    logic [4:0] osc_cnt_reg; // Oscillator periods in this cycle
    ncd_pkg::ncd_phase_t phase_reg; // Bus phase
    ncd_pkg::ncd_ind_t ind_reg; // Indirect fetch in flight
    logic osc_d_reg; // Previous oscillator level
    logic ser_d_reg; // Previous serial level
    logic [2:0] row_select; // Pointer row
    logic [3:0] digit_select; // Pointer digit
    logic [3:0] acc_reg; // Accumulator
    logic carry_reg; // Carry
    logic [7:0] q_reg; // Port latch
    logic [3:0] d_reg; // Digit outputs
    logic [3:0] g_reg; // General register
    logic [3:0] serial_shift_counter; // Shift register or counter
    logic skl_reg; // Serial clock latch
    logic [7:0] fetch_reg; // Last fetched byte
    logic pulse_reg; // Cycle boundary marker
    logic sk_reg; // Serial clock pin
    logic so_reg; // Serial data pin
    logic skp_reg; // Skip or top address pin
    logic [7:0] l_oe_reg; // Byte port enables
    // 512-bit RAM; not cleared at reset
    logic [3:0] ram [ncd_pkg::RAM_WORDS];

    // Oscillator edge and cycle boundary decode
    wire osc_tick = osc_s & ~osc_d_reg;
    wire boundary = osc_tick && (osc_cnt_reg == ncd_pkg::CNT_LAST);
    wire to_data = osc_tick && (osc_cnt_reg == ncd_pkg::CNT_HALF - 5'h01);
    wire ser_fall = ser_d_reg & ~ser_s;
    wire cnt_mode = enable_bits[ncd_pkg::EN_CNT];
    // Ops only act at a boundary with no indirect fetch pending
    wire run = boundary && (ind_reg == ncd_pkg::IND_NONE);

    wire [6:0] ptr = {row_select, digit_select};
    wire is_direct = (op_code == ncd_pkg::OP_LDD) || (op_code == ncd_pkg::OP_XAD);
    wire [6:0] ram_addr = is_direct ? op_arg[6:0] : ptr;
    wire [3:0] ram_q = ram[ram_addr];
    wire [3:0] q_half = op_high_half ? q_reg[7:4] : q_reg[3:0];
    wire [3:0] l_half = op_high_half ? l_s[7:4] : l_s[3:0];

    wire [4:0] sum_adc = add4(acc_reg, ram_q, carry_reg);
    wire [4:0] sum_add = add4(acc_reg, ram_q, 1'b0);
    wire [4:0] sum_imm = add4(acc_reg, op_arg[3:0], 1'b0);

    wire is_call = (op_code == ncd_pkg::OP_CALL) || (op_code == ncd_pkg::OP_PCALL)
        || (op_code == ncd_pkg::OP_TLOAD);
    assign stk_if.push = run && is_call;
    assign stk_if.pop = (run && (op_code == ncd_pkg::OP_RET))
        || (boundary && (ind_reg == ncd_pkg::IND_TABLE));
    assign stk_if.push_val = inc11(pc_reg);

    // Byte on the bus as the data phase closes
    wire [7:0] fetch_sample = ibus_s;

    // Next program counter
    logic [10:0] pc_next;
    always_comb begin
        pc_next = pc_reg;
        if (boundary) begin
            pc_next = inc11(pc_reg);
            if (ind_reg == ncd_pkg::IND_JUMP) begin
                pc_next = {pc_reg[10:8], fetch_sample};
            end else if (ind_reg == ncd_pkg::IND_TABLE) begin
                pc_next = stk_if.top_val;
            end else begin
                case (op_code)
                    ncd_pkg::OP_JMP, ncd_pkg::OP_CALL: pc_next = op_arg;
                    ncd_pkg::OP_RET: pc_next = stk_if.top_val;
                    ncd_pkg::OP_PJMP: pc_next = {pc_reg[10:6], op_arg[5:0]};
                    ncd_pkg::OP_PCALL: pc_next = {ncd_pkg::PCALL_PAGE, op_arg[5:0]};
                    ncd_pkg::OP_IJMP,
                    ncd_pkg::OP_TLOAD: pc_next = {pc_reg[10:8], acc_reg, ram_q};
                    default: pc_next = inc11(pc_reg);
                endcase
            end
        end
    end

    // Phase and oscillator count
    // 32 periods per cycle
    // one high and one low phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_reg <= ncd_pkg::CNT_RST;
            phase_reg <= ncd_pkg::PH_ADDR;
            osc_d_reg <= 1'b0;
            ser_d_reg <= 1'b0;
        end else begin
            osc_d_reg <= osc_s;
            ser_d_reg <= ser_s;
            if (osc_tick) begin
                osc_cnt_reg <= osc_cnt_reg + 5'h01;
            end
            case (phase_reg)
                ncd_pkg::PH_ADDR: if (to_data) phase_reg <= ncd_pkg::PH_DATA;
                ncd_pkg::PH_DATA: if (boundary) phase_reg <= ncd_pkg::PH_ADDR;
                default: phase_reg <= ncd_pkg::PH_ADDR;
            endcase
        end
    end

    // program counter, fetch capture and indirect state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= ncd_pkg::PC_RST;
            fetch_reg <= ncd_pkg::BYTE_RST;
            pulse_reg <= 1'b0;
            ind_reg <= ncd_pkg::IND_NONE;
        end else begin
            pc_reg <= pc_next;
            pulse_reg <= boundary;
            if (boundary) begin
                fetch_reg <= fetch_sample;
                ind_reg <= ncd_pkg::IND_NONE;
                if (run && op_code == ncd_pkg::OP_IJMP) ind_reg <= ncd_pkg::IND_JUMP;
                if (run && op_code == ncd_pkg::OP_TLOAD) ind_reg <= ncd_pkg::IND_TABLE;
            end
        end
    end

    // RAM writes; nibble moves with A, Q and L
    always_ff @(posedge clk_sys) begin
        if (run) begin
            case (op_code)
                ncd_pkg::OP_ST, ncd_pkg::OP_XCH,
                ncd_pkg::OP_XAD: ram[ram_addr] <= acc_reg;
                ncd_pkg::OP_Q2M: ram[ram_addr] <= q_half;
                ncd_pkg::OP_L2M: ram[ram_addr] <= l_half;
                default: ;
            endcase
        end
    end

    // Accumulator and carry
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= ncd_pkg::NIB_RST;
            carry_reg <= 1'b0;
        end else if (run) begin
            case (op_code)
                ncd_pkg::OP_LD, ncd_pkg::OP_XCH, ncd_pkg::OP_LDD,
                ncd_pkg::OP_XAD: acc_reg <= ram_q;
                ncd_pkg::OP_Q2A: acc_reg <= q_half;
                ncd_pkg::OP_L2A: acc_reg <= l_half;
                ncd_pkg::OP_XAS: acc_reg <= serial_shift_counter;
                ncd_pkg::OP_ADC: {carry_reg, acc_reg} <= sum_adc;
                ncd_pkg::OP_ADD: acc_reg <= sum_add[3:0];
                ncd_pkg::OP_ADDI: acc_reg <= sum_imm[3:0];
                ncd_pkg::OP_COMP: acc_reg <= ~acc_reg;
                ncd_pkg::OP_CLRA: acc_reg <= ncd_pkg::NIB_RST;
                ncd_pkg::OP_G2A: acc_reg <= g_s;
                ncd_pkg::OP_IN2A: acc_reg <= in_s;
                default: ;
            endcase
        end
    end

    // Pointer, port latch, digit and general registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {row_select, digit_select} <= ncd_pkg::PTR_RST;
            q_reg <= ncd_pkg::BYTE_RST;
            d_reg <= ncd_pkg::NIB_RST;
            g_reg <= ncd_pkg::NIB_RST;
        end else if (boundary && ind_reg == ncd_pkg::IND_TABLE) begin
            // table byte into the port latch
            q_reg <= fetch_sample;
        end else if (run) begin
            case (op_code)
                ncd_pkg::OP_LBI: {row_select, digit_select} <= op_arg[6:0];
                // accumulator loads pointer and Q halves
                ncd_pkg::OP_A2BR: row_select <= acc_reg[2:0];
                ncd_pkg::OP_A2BD: digit_select <= acc_reg;
                ncd_pkg::OP_A2Q: if (op_high_half) q_reg[7:4] <= acc_reg;
                    else q_reg[3:0] <= acc_reg;
                ncd_pkg::OP_AM2Q: q_reg <= {acc_reg, ram_q};
                ncd_pkg::OP_BD2D: d_reg <= digit_select;
                ncd_pkg::OP_A2G: g_reg <= acc_reg;
                default: ;
            endcase
        end
    end

    // Serial register and its clock latch
    // lowest enable bit picks counter mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial_shift_counter <= ncd_pkg::NIB_RST;
            skl_reg <= 1'b1; // Reset leaves the sync clock running
        end else if (run && op_code == ncd_pkg::OP_XAS) begin
            // carry copied into the clock latch
            serial_shift_counter <= acc_reg;
            skl_reg <= carry_reg;
        end else if (cnt_mode) begin
            // counter steps down on each input fall, except one that lands on the clock of an XAS swap
            if (ser_fall) serial_shift_counter <= serial_shift_counter - 4'h1;
        end else if (boundary) begin
            serial_shift_counter <= {serial_shift_counter[2:0], ser_s};
        end
    end

    // Phase that the coming edge loads; pins track it with no extra lag
    wire ncd_pkg::ncd_phase_t phase_next = boundary ? ncd_pkg::PH_ADDR
        : (to_data ? ncd_pkg::PH_DATA : phase_reg);

    // Pin registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sk_reg <= 1'b0;
            so_reg <= 1'b0;
            skp_reg <= 1'b0;
            l_oe_reg <= ncd_pkg::BYTE_RST;
        end else begin
            // latch direct, or gated by the cycle clock
            sk_reg <= cnt_mode ? skl_reg : (skl_reg & (phase_next == ncd_pkg::PH_ADDR));
            so_reg <= enable_bits[ncd_pkg::EN_SO] & (cnt_mode | serial_shift_counter[3]);
            // top address bit, then skip flag
            skp_reg <= (phase_next == ncd_pkg::PH_ADDR) ? pc_next[10] : skip_flag;
            l_oe_reg <= {8{enable_bits[ncd_pkg::EN_LDRV]}};
        end
    end
    // shared bus drives the address in the high phase
    // bus released during the data phase
    assign instr_bus_out = pc_reg[7:0];
    assign instr_bus_oe = (phase_reg == ncd_pkg::PH_ADDR);
    assign addr_phase = (phase_reg == ncd_pkg::PH_ADDR);
    assign addr_bit_eight = pc_reg[8];
    assign addr_bit_nine = pc_reg[9];
    assign skip_or_top_addr = skp_reg;
    assign d_out = d_reg;
    assign g_out = g_reg;
    assign g_oe = 4'hF;
    assign l_out = q_reg;
    assign l_oe = l_oe_reg;
    assign serial_clock_pin = sk_reg;
    assign serial_out = so_reg;
    assign instr_byte = fetch_reg;
    assign cycle_pulse = pulse_reg;
    assign acc_value = acc_reg;
    assign carry_value = carry_reg;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_PC_SEQ: assert property (
        run && op_code == ncd_pkg::OP_NOP |=> pc_reg == inc11($past(pc_reg)))
        else $error("PC did not step by one");
    AST_RET_POP: assert property (
        run && op_code == ncd_pkg::OP_RET |=> pc_reg == $past(stk_if.top_val))
        else $error("Return did not load stack top");
    AST_CALL_RET: assert property (
        run && op_code == ncd_pkg::OP_CALL |=> stk_if.top_val == inc11($past(pc_reg)))
        else $error("Call did not push return address");
    AST_HALF: assert property (
        phase_reg == ncd_pkg::PH_DATA && $past(phase_reg) == ncd_pkg::PH_ADDR
        |-> osc_cnt_reg == ncd_pkg::CNT_HALF)
        else $error("Data phase began at wrong count");
    AST_WRAP: assert property (
        boundary |=> osc_cnt_reg == ncd_pkg::CNT_RST && phase_reg == ncd_pkg::PH_ADDR)
        else $error("Cycle did not end after 32 periods");
    AST_BUS: assert property (
        phase_reg == ncd_pkg::PH_DATA |-> !instr_bus_oe && !addr_phase)
        else $error("Bus driven in data phase");
    AST_LDRV: assert property (
        enable_bits[ncd_pkg::EN_LDRV] ##1 enable_bits[ncd_pkg::EN_LDRV]
        |-> l_oe == 8'hFF && l_out == q_reg)
        else $error("Byte port drivers not enabled");
    AST_SHIFT: assert property (
        boundary && !cnt_mode && !(run && op_code == ncd_pkg::OP_XAS)
        |=> serial_shift_counter == {$past(serial_shift_counter[2:0]), $past(ser_s)})
        else $error("Serial register did not shift");
    AST_ADC: assert property (
        run && op_code == ncd_pkg::OP_ADC |=> {carry_reg, acc_reg} == $past(sum_adc))
        else $error("Adder result lost");
    AST_DIGIT: assert property (
        run && op_code == ncd_pkg::OP_BD2D |=> ##1 d_out == $past(digit_select, 2))
        else $error("Digit outputs not loaded");
    AST_SK_CNT: assert property (
        cnt_mode && $stable(skl_reg) |=> serial_clock_pin == $past(skl_reg))
        else $error("Serial clock not following latch");

    COV_CALL_RET: cover property (run && op_code == ncd_pkg::OP_CALL
        ##[1:1000] run && op_code == ncd_pkg::OP_RET);
    COV_TABLE: cover property (boundary && ind_reg == ncd_pkg::IND_TABLE);
    COV_COUNT: cover property (cnt_mode && ser_fall);
endmodule : ncd_core

// [design/ncd_pkg.sv]
// Shared constants and types for the nibble CPU datapath
package ncd_pkg;
    // Widths of the datapath fields
    localparam int PC_W = 11;
    localparam int ROW_W = 3;
    localparam int DIG_W = 4;
    localparam int PTR_W = 7;
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    localparam int RAM_WORDS = 128;
    localparam int PAGE_WORDS = 64;
    localparam int PAGE_COUNT = 32;
    // Instruction cycle framing, counted in oscillator periods
    localparam int OSC_PER_CYC = 32;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_HALF = 5'h10;
    localparam logic [4:0] CNT_LAST = 5'h1F;
    localparam logic [4:0] CNT_RST = 5'h00;
    // Reset values
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Page used by the page call; default value only
    localparam logic [4:0] PCALL_PAGE = 5'h02;
    // Enable bit positions
    localparam int EN_CNT = 0;
    localparam int EN_LDRV = 2;
    localparam int EN_SO = 3;
    // Bus phase within one instruction cycle
    typedef enum logic [1:0] {PH_ADDR = 2'b00, PH_DATA = 2'b01} ncd_phase_t;
    // Pending indirect fetch, Gray along the usual path
    typedef enum logic [1:0] {
        IND_NONE = 2'b00, IND_JUMP = 2'b01, IND_TABLE = 2'b11
    } ncd_ind_t;
    // Datapath operations presented by the decoder
    typedef enum logic [4:0] {
        OP_NOP, OP_JMP, OP_CALL, OP_RET, OP_PJMP, OP_PCALL, OP_IJMP,
        OP_TLOAD, OP_LBI, OP_LD, OP_ST, OP_XCH, OP_LDD, OP_XAD,
        OP_A2BR, OP_A2BD, OP_A2Q, OP_Q2A, OP_L2A, OP_AM2Q, OP_Q2M,
        OP_L2M, OP_XAS, OP_ADC, OP_ADD, OP_ADDI, OP_COMP, OP_CLRA,
        OP_BD2D, OP_A2G, OP_G2A, OP_IN2A
    } ncd_op_t;
endpackage : ncd_pkg

// [design/ncd_stack_if.sv]
// Interface between the core and its return stack
`timescale 1ns/1ps
interface ncd_stack_if;
    logic push; // Shift in a return address
    logic pop; // Remove the top entry
    logic [10:0] push_val; // Address pushed
    logic [10:0] top_val; // Current top entry
    modport owner (output push, output pop, output push_val, input top_val);
    modport store (input push, input pop, input push_val, output top_val);
endinterface : ncd_stack_if

// [design/ncd_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ncd_sync3 #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    // Stage registers; only stage two reads stage one
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // Output only moves once the last two stages agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_out <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_out <= s3_reg;
            end
        end
    end
endmodule : ncd_sync3

// [design/ncd_ret_stack.sv]
// Three-level last-in first-out return address stack
`timescale 1ns/1ps
module ncd_ret_stack (
    input wire logic clk_sys,
    input wire logic rst_n,
    ncd_stack_if.store stk
);
    // Save registers, top first
    logic [10:0] stack_level_top_reg;
    logic [10:0] stack_level_mid_reg;
    logic [10:0] stack_level_bottom_reg;

    assign stk.top_val = stack_level_top_reg;

    // three-level LIFO
    // Push drops the bottom entry; pop refills from below
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stack_level_top_reg <= ncd_pkg::PC_RST;
            stack_level_mid_reg <= ncd_pkg::PC_RST;
            stack_level_bottom_reg <= ncd_pkg::PC_RST;
        end else if (stk.push) begin
            stack_level_top_reg <= stk.push_val;
            stack_level_mid_reg <= stack_level_top_reg;
            stack_level_bottom_reg <= stack_level_mid_reg;
        end else if (stk.pop) begin
            stack_level_top_reg <= stack_level_mid_reg;
            stack_level_mid_reg <= stack_level_bottom_reg;
        end
    end
endmodule : ncd_ret_stack

// [tb/ncd_prog_mem.sv]
// External program memory with its low-address latch
`timescale 1ns/1ps
module ncd_prog_mem (
    input wire logic clk_sys,
    input wire logic addr_phase,
    input wire logic [10:0] addr_pins,
    output logic [7:0] mem_data
);
    logic [10:0] hold_reg; // Pins seen while address phase
    logic [10:0] addr_reg; // Latched word address
    // Sample pins each address-phase clock so the latch never races the skip pin
    always @(posedge clk_sys) if (addr_phase) hold_reg <= addr_pins;
    always @(negedge addr_phase) addr_reg = hold_reg;
    // Drive the byte in data phase; inverse in address phase, never stale
    assign mem_data = (addr_reg[7:0] ^ {addr_reg[10:8], 5'h0A}) ^ {8{addr_phase}};
endmodule : ncd_prog_mem

// [tb/test_ncd_core.sv]
// Self-checking bench for the nibble datapath core
`timescale 1ns/1ps
module test_ncd_core;
    logic clk_sys = 1'h0, rst_n = 1'h0, osc_input = 1'h0, ser_pin = 1'h0, op_high_half;
    logic [1:0] div = 2'h0; // Oscillator divider, 8 clocks per period
    logic [7:0] instr_bus_in, instr_bus_out, l_out, l_oe, instr_byte, mem_data;
    logic instr_bus_oe, addr_phase, addr_bit_eight, addr_bit_nine, skip_or_top_addr;
    logic serial_clock_pin, serial_out, cycle_pulse, carry_value;
    logic [3:0] enable_bits, d_out, g_out, g_oe, acc_value;
    logic [10:0] op_arg, a, pc_now;
    logic [10:0] rs [3]; // Expected return addresses
    ncd_pkg::ncd_op_t op_code;
    int samples_checked = 0, n_mismatch = 0, wait_n, k;
    assign pc_now = {skip_or_top_addr, addr_bit_nine, addr_bit_eight, instr_bus_out};
    // Bus wire: device wins while it drives, else the memory
    assign instr_bus_in = instr_bus_oe ? instr_bus_out : mem_data;
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        div <= div + 2'h1;
        if (div == 2'h3) osc_input <= ~osc_input;
    end
    // Port pins loop back, so a read sees what the device drives
    ncd_core uut (.clk_sys, .rst_n, .osc_input, .instr_bus_in, .instr_bus_out,
        .instr_bus_oe, .addr_phase, .addr_bit_eight, .addr_bit_nine, .skip_or_top_addr,
        .skip_flag(1'h0), .op_code, .op_arg, .op_high_half, .enable_bits, .d_out,
        .g_in(g_out), .g_out, .g_oe, .l_in(l_oe[0] ? l_out : 8'h00), .l_out, .l_oe,
        .gp_sense_lines(4'h0), .serial_in(ser_pin), .serial_clock_pin, .serial_out,
        .instr_byte, .cycle_pulse, .acc_value, .carry_value);
    ncd_prog_mem mem (.clk_sys, .addr_phase, .addr_pins(pc_now), .mem_data);
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task check(input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One instruction cycle; returns just after the completion pulse
    task op(input ncd_pkg::ncd_op_t o, input logic [10:0] arg);
        @(posedge clk_sys);
        op_code <= o;
        op_arg <= arg;
        wait_n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            wait_n++;
        end while (cycle_pulse !== 1'h1 && wait_n < 600);
        if (wait_n >= 600) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : op
    initial begin
        op_code = ncd_pkg::OP_NOP;
        op_arg = 11'h000;
        op_high_half = 1'h1;
        enable_bits = 4'h0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        op(ncd_pkg::OP_NOP, 11'h000);
        a = pc_now;
        op(ncd_pkg::OP_NOP, 11'h000);
        check(pc_now, a + 11'h001);
        check(11'(wait_n + 1), 11'h100);
        check(instr_byte, a[7:0] ^ {a[10:8], 5'h0A});
        check({instr_bus_oe, addr_phase}, 11'h003);
        op(ncd_pkg::OP_JMP, 11'h7FF);
        check(pc_now, 11'h7FF);
        op(ncd_pkg::OP_NOP, 11'h000);
        check(pc_now, 11'h000);
        $display("test fetch done");
        // Three nested calls, then unwind in reverse
        for (k = 0; k < 3; k++) begin
            rs[k] = pc_now + 11'h001;
            op(ncd_pkg::OP_CALL, 11'h100 + 11'(k * 16));
        end
        for (k = 2; k >= 0; k--) begin
            op(ncd_pkg::OP_RET, 11'h000);
            check(pc_now, rs[k]);
        end
        op(ncd_pkg::OP_PCALL, 11'h03F);
        check(pc_now, {ncd_pkg::PCALL_PAGE, 6'h3F});
        $display("test stack done");
        op(ncd_pkg::OP_CLRA, 11'h000);
        op(ncd_pkg::OP_ADDI, 11'h009);
        op(ncd_pkg::OP_LBI, 11'h035);
        op(ncd_pkg::OP_ST, 11'h000);
        op(ncd_pkg::OP_ADDI, 11'h009);
        check({carry_value, acc_value}, 11'h002);
        op(ncd_pkg::OP_ADC, 11'h000);
        op(ncd_pkg::OP_ADC, 11'h000);
        check({carry_value, acc_value}, 11'h014);
        op(ncd_pkg::OP_CLRA, 11'h000);
        op(ncd_pkg::OP_LDD, 11'h035);
        check(acc_value, 11'h009);
        op(ncd_pkg::OP_BD2D, 11'h000);
        check(d_out, 11'h005);
        @(posedge clk_sys);
        enable_bits <= 4'h4;
        op(ncd_pkg::OP_A2Q, 11'h000);
        op(ncd_pkg::OP_A2G, 11'h000);
        check(l_oe, 11'h0FF);
        check(l_out[7:4], 11'h009);
        check(g_out, 11'h009);
        op(ncd_pkg::OP_A2BD, 11'h000);
        op(ncd_pkg::OP_BD2D, 11'h000);
        check(d_out, 11'h009);
        // Read back the driven byte and general port pins
        op(ncd_pkg::OP_CLRA, 11'h000);
        op(ncd_pkg::OP_L2A, 11'h000);
        check(acc_value, 11'h009);
        op(ncd_pkg::OP_CLRA, 11'h000);
        op(ncd_pkg::OP_G2A, 11'h000);
        check({g_oe, acc_value}, 11'h0F9);
        $display("test alu done");
        // Counter mode: swap in 9, one input fall, swap out 8
        @(posedge clk_sys);
        enable_bits <= 4'hD;
        ser_pin <= 1'h1;
        op(ncd_pkg::OP_XAS, 11'h000);
        check({serial_clock_pin, serial_out, acc_value}, 11'h030);
        op(ncd_pkg::OP_NOP, 11'h000);
        @(posedge clk_sys);
        ser_pin <= 1'h0;
        op(ncd_pkg::OP_NOP, 11'h000);
        op(ncd_pkg::OP_XAS, 11'h000);
        check(acc_value, 11'h008);
        $display("test serial done");
        wrap_up();
    end
endmodule : test_ncd_core
